// [verilog/sdm_mode_regs.v]
/*
  Three-wire serial control port and the mode-register bank it fills, with
  the per-channel attenuation ramps.
  Assumes the three control pins are asynchronous to clk_sys_i and change
  far slower than it (shift clock period of 160 ns or more).
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdm_consts.vh"

// Notes on behaviour
// - Control port runs apart from audio timing
// - One write is exactly one 16-bit frame
// - Frame bits 14..8 select target register
// - Frame low byte is the stored value
// - Latch rising commits data to indexed register
// - Indices 0x10..0x16 map the seven registers
// - Per-channel attenuation, resets to no attenuation
// - Oversampling bit 6, soft mutes bits 1..0
// - Output disables bits 1..0, reset enabled
// - De-emphasis enable bit 4, rate bits 6..5
// - Format bits 2..0, default left-justified
// - Roll-off bit 5, default sharp
// - Zero-flag mode bit 2, default independent
// - Zero polarity bit 1, phase bit 0
// - Codes 128 and below mean mute
// - Format codes decode, 110 and 111 reserved
// - De-emphasis rate codes, 11 reserved
// - Soft mute ramps one step per tick
module sdm_mode_regs #(
  parameter RAMP_STEP_CYCLES = `SDM_RAMP_STEP_CYCLES
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire ctl_serial_in_i,
  input wire ctl_shift_clk_i,
  input wire ctl_latch_i,
  output reg [7:0] left_atten_code_o,
  output reg [7:0] right_atten_code_o,
  output wire [7:0] left_atten_level_o,
  output wire [7:0] right_atten_level_o,
  output reg left_muted_o,
  output reg right_muted_o,
  output reg oversample_128_o,
  output reg left_soft_mute_o,
  output reg right_soft_mute_o,
  output reg left_output_disable_o,
  output reg right_output_disable_o,
  output reg deemph_enable_o,
  output reg [1:0] deemph_rate_sel_o,
  output reg deemph_rate_rsvd_o,
  output reg [2:0] input_format_sel_o,
  output reg input_format_rsvd_o,
  output reg rolloff_sel_o,
  output reg zero_flag_mode_sel_o,
  output reg zero_flag_polarity_o,
  output reg output_phase_invert_o,
  output reg [7:0] test_reserved_bit_o,
  output reg write_strobe_o,
  output reg frame_reject_o
);

  // Pin order inside the synchroniser bus
  localparam PIN_DATA = 0;
  localparam PIN_SCK = 1;
  localparam PIN_LATCH = 2;

  // Frame receiver states
  localparam ST_IDLE = 1'b0;
  localparam ST_FRAME = 1'b1;

  wire [2:0] pins_raw;
  wire [2:0] sync_b;
  reg sck_prev;
  reg latch_prev;
  reg state;
  reg [15:0] shift_reg;
  reg [4:0] bit_cnt;
  wire sck_rise;
  wire latch_fall;
  wire latch_rise;
  wire [6:0] frame_idx;
  wire [7:0] frame_data;
  wire frame_ok;

  // Known-range check on an index, used for accept and reject
  function idx_in_map;
    input [6:0] idx;
    begin
      idx_in_map = (idx >= `SDM_IDX_LEFT_ATTEN) && (idx <= `SDM_IDX_FLAG_PHASE);
    end
  endfunction

  // Mute decode of an attenuation level
  function atten_is_mute;
    input [7:0] code;
    begin
      atten_is_mute = (code <= `SDM_ATTEN_MUTE);
    end
  endfunction

  assign pins_raw = {ctl_latch_i, ctl_shift_clk_i, ctl_serial_in_i};

  // Two-flop synchronisers for every control pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      reg stage_a;
      reg stage_b;
      always @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          stage_a <= (gi == PIN_LATCH) ? 1'b1 : 1'b0;
          stage_b <= (gi == PIN_LATCH) ? 1'b1 : 1'b0;
        end
        else if (clk_en_i)
        begin
          stage_a <= pins_raw[gi];
          stage_b <= stage_a;
        end
      end
      // Only the second stage feeds the edge logic
      assign sync_b[gi] = stage_b;
    end
  endgenerate

  // Edge history of the synchronised shift clock and latch
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sck_prev <= 1'b0;
      latch_prev <= 1'b1;
    end
    else if (clk_en_i)
    begin
      sck_prev <= sync_b[PIN_SCK];
      latch_prev <= sync_b[PIN_LATCH];
    end
  end

  assign sck_rise = sync_b[PIN_SCK] & ~sck_prev;
  assign latch_fall = ~sync_b[PIN_LATCH] & latch_prev;
  assign latch_rise = sync_b[PIN_LATCH] & ~latch_prev;
  assign frame_idx = shift_reg[`SDM_IDX_HI:`SDM_IDX_LO];
  assign frame_data = shift_reg[`SDM_DATA_HI:`SDM_DATA_LO];
  assign frame_ok = (bit_cnt == `SDM_FRAME_BITS) && idx_in_map(frame_idx);

  // Frame receiver: latch low opens a frame, shift clock rises load bits
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_IDLE;
      shift_reg <= 16'h0000;
      bit_cnt <= 5'h00;
    end
    else if (clk_en_i)
    begin
      case (state)
        ST_IDLE:
        begin
          if (latch_fall)
          begin
            state <= ST_FRAME;
            bit_cnt <= 5'h00;
          end
        end
        ST_FRAME:
        begin
          if (latch_rise)
            state <= ST_IDLE;
          else if (sck_rise)
          begin
            shift_reg <= {shift_reg[14:0], sync_b[PIN_DATA]};
            if (bit_cnt != 5'h1f)
              bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Commit strobe and reject pulse at the end of a frame
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      write_strobe_o <= 1'b0;
      frame_reject_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      write_strobe_o <= (state == ST_FRAME) && latch_rise && frame_ok;
      frame_reject_o <= (state == ST_FRAME) && latch_rise && !frame_ok;
    end
  end

  // Mode register bank, written only by a good frame
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      left_atten_code_o <= `SDM_RST_ATTEN;
      right_atten_code_o <= `SDM_RST_ATTEN;
      oversample_128_o <= 1'b0;
      left_soft_mute_o <= 1'b0;
      right_soft_mute_o <= 1'b0;
      left_output_disable_o <= 1'b0;
      right_output_disable_o <= 1'b0;
      deemph_enable_o <= 1'b0;
      deemph_rate_sel_o <= `SDM_RST_DEEMPH_RATE;
      input_format_sel_o <= `SDM_RST_FMT;
      rolloff_sel_o <= 1'b0;
      zero_flag_mode_sel_o <= 1'b0;
      zero_flag_polarity_o <= 1'b0;
      output_phase_invert_o <= 1'b0;
      test_reserved_bit_o <= `SDM_RST_BYTE;
    end
    else if (clk_en_i && (state == ST_FRAME) && latch_rise && frame_ok)
    begin
      case (frame_idx)
        `SDM_IDX_LEFT_ATTEN:
          left_atten_code_o <= frame_data;
        `SDM_IDX_RIGHT_ATTEN:
          right_atten_code_o <= frame_data;
        `SDM_IDX_MUTE_RATE:
        begin
          oversample_128_o <= frame_data[`SDM_BIT_OVERSAMPLE];
          right_soft_mute_o <= frame_data[`SDM_BIT_RIGHT_MUTE];
          left_soft_mute_o <= frame_data[`SDM_BIT_LEFT_MUTE];
        end
        `SDM_IDX_CHAN_DEEMPH:
        begin
          deemph_rate_sel_o <= frame_data[`SDM_BIT_DEEMPH_RATE_HI:`SDM_BIT_DEEMPH_RATE_LO];
          deemph_enable_o <= frame_data[`SDM_BIT_DEEMPH_EN];
          right_output_disable_o <= frame_data[`SDM_BIT_RIGHT_DISABLE];
          left_output_disable_o <= frame_data[`SDM_BIT_LEFT_DISABLE];
        end
        `SDM_IDX_FMT_FILTER:
        begin
          rolloff_sel_o <= frame_data[`SDM_BIT_ROLLOFF];
          input_format_sel_o <= frame_data[`SDM_BIT_FMT_HI:`SDM_BIT_FMT_LO];
        end
        `SDM_IDX_RESERVED:
          test_reserved_bit_o <= frame_data;
        `SDM_IDX_FLAG_PHASE:
        begin
          zero_flag_mode_sel_o <= frame_data[`SDM_BIT_ZERO_MODE];
          zero_flag_polarity_o <= frame_data[`SDM_BIT_ZERO_POL];
          output_phase_invert_o <= frame_data[`SDM_BIT_PHASE_INV];
        end
        default:
          test_reserved_bit_o <= test_reserved_bit_o;
      endcase
    end
  end

  // Reserved-code flags for the format and de-emphasis rate fields
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      input_format_rsvd_o <= 1'b0;
      deemph_rate_rsvd_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      input_format_rsvd_o <= (input_format_sel_o >= `SDM_FMT_RSVD_MIN);
      deemph_rate_rsvd_o <= (deemph_rate_sel_o == `SDM_DEEMPH_RATE_RSVD);
    end
  end

  // Attenuation ramps, one per channel
  sdm_atten_ramp #(
    .STEP_CYCLES(RAMP_STEP_CYCLES)
  ) u_left_ramp (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .target_code_i(left_atten_code_o),
    .soft_mute_i(left_soft_mute_o),
    .level_o(left_atten_level_o)
  );

  sdm_atten_ramp #(
    .STEP_CYCLES(RAMP_STEP_CYCLES)
  ) u_right_ramp (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .target_code_i(right_atten_code_o),
    .soft_mute_i(right_soft_mute_o),
    .level_o(right_atten_level_o)
  );

  // Live mute indication from the ramped levels
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      left_muted_o <= 1'b0;
      right_muted_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      left_muted_o <= atten_is_mute(left_atten_level_o);
      right_muted_o <= atten_is_mute(right_atten_level_o);
    end
  end

endmodule
`default_nettype wire

// [verilog/sdm_consts.vh]
/*
  Constants for the serial mode-register bank: frame layout, register
  indices, field positions, reset values and timing counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH

// Frame layout
`define SDM_FRAME_BITS 5'h10
`define SDM_FRAME_ZERO_BIT 15
`define SDM_IDX_HI 14
`define SDM_IDX_LO 8
`define SDM_DATA_HI 7
`define SDM_DATA_LO 0

// Register indices
`define SDM_IDX_LEFT_ATTEN 7'h10
`define SDM_IDX_RIGHT_ATTEN 7'h11
`define SDM_IDX_MUTE_RATE 7'h12
`define SDM_IDX_CHAN_DEEMPH 7'h13
`define SDM_IDX_FMT_FILTER 7'h14
`define SDM_IDX_RESERVED 7'h15
`define SDM_IDX_FLAG_PHASE 7'h16

// Field positions
`define SDM_BIT_OVERSAMPLE 6
`define SDM_BIT_RIGHT_MUTE 1
`define SDM_BIT_LEFT_MUTE 0
`define SDM_BIT_DEEMPH_RATE_HI 6
`define SDM_BIT_DEEMPH_RATE_LO 5
`define SDM_BIT_DEEMPH_EN 4
`define SDM_BIT_RIGHT_DISABLE 1
`define SDM_BIT_LEFT_DISABLE 0
`define SDM_BIT_ROLLOFF 5
`define SDM_BIT_FMT_HI 2
`define SDM_BIT_FMT_LO 0
`define SDM_BIT_ZERO_MODE 2
`define SDM_BIT_ZERO_POL 1
`define SDM_BIT_PHASE_INV 0

// Reset values
`define SDM_RST_ATTEN 8'hff
`define SDM_RST_FMT 3'h5
`define SDM_RST_DEEMPH_RATE 2'h0
`define SDM_RST_BYTE 8'h00

// Attenuation codes
`define SDM_ATTEN_MUTE 8'h80
`define SDM_ATTEN_FULL 8'hff

// Format and de-emphasis codes that are reserved
`define SDM_FMT_RSVD_MIN 3'h6
`define SDM_DEEMPH_RATE_RSVD 2'h3

// Timing: one ramp step per 8 sample periods at 48 kHz
`define SDM_CLK_PERIOD_NS 10
`define SDM_RAMP_STEP_NS 166667
`define SDM_RAMP_STEP_CYCLES (`SDM_RAMP_STEP_NS / `SDM_CLK_PERIOD_NS)

`endif

// [verilog/sdm_atten_ramp.v]
/*
  One channel's attenuation ramp: the live level walks one 0.5 dB step per
  tick toward the programmed code, or toward mute while soft mute is set.
  Assumes a single clock domain; all inputs come from flops on clk_sys_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdm_consts.vh"

module sdm_atten_ramp #(
  parameter STEP_CYCLES = `SDM_RAMP_STEP_CYCLES
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire [7:0] target_code_i,
  input wire soft_mute_i,
  output reg [7:0] level_o
);

  localparam CW = $clog2(STEP_CYCLES + 1);
  localparam [31:0] STEP_LAST_W = STEP_CYCLES - 1;
  localparam [CW-1:0] STEP_LAST = STEP_LAST_W[CW-1:0];

  reg [CW-1:0] tick_cnt;
  reg [7:0] next_target;

  // Codes 128 and below all mean mute; soft mute forces the mute floor
  always @*
  begin
    if (soft_mute_i)
      next_target = `SDM_ATTEN_MUTE;
    else if (target_code_i <= `SDM_ATTEN_MUTE)
      next_target = `SDM_ATTEN_MUTE;
    else
      next_target = target_code_i;
  end

  // Step timer and one-step-per-tick level walk
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      tick_cnt <= {CW{1'b0}};
      level_o <= `SDM_RST_ATTEN;
    end
    else if (clk_en_i)
    begin
      if (tick_cnt == STEP_LAST)
      begin
        tick_cnt <= {CW{1'b0}};
        if (level_o > next_target)
          level_o <= level_o - 8'h01;
        else if (level_o < next_target)
          level_o <= level_o + 8'h01;
      end
      else
        tick_cnt <= tick_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// [testbench/sdm_regs_chk.sv]
/* Checker on the mode-register bank ports.
   Assumes clk_en_i is low only while the control pins are idle. */
`timescale 1ns/100ps
`default_nettype none
module sdm_regs_chk #(
  parameter RAMP_STEP_CYCLES = 4
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire ctl_latch_i,
  input wire [7:0] left_atten_code_o,
  input wire [7:0] left_atten_level_o,
  input wire left_muted_o,
  input wire [1:0] deemph_rate_sel_o,
  input wire deemph_rate_rsvd_o,
  input wire [2:0] input_format_sel_o,
  input wire input_format_rsvd_o,
  input wire write_strobe_o,
  input wire frame_reject_o
);
  // All checks on the system clock, quiet in reset
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  strobe_one_a: assert property (write_strobe_o |=> !write_strobe_o)
    else $error("commit strobe longer than one cycle");
  strobe_excl_a: assert property (!(write_strobe_o && frame_reject_o))
    else $error("commit and reject together");
  bank_hold_a: assert property (!write_strobe_o |->
    $stable({left_atten_code_o, input_format_sel_o, deemph_rate_sel_o}))
    else $error("register changed without commit");
  commit_time_a: assert property ($rose(ctl_latch_i) |-> ##[3:6] (write_strobe_o || frame_reject_o))
    else $error("no answer after latch rise");
  mute_flag_a: assert property (left_muted_o == ($past(left_atten_level_o) <= 8'h80))
    else $error("muted flag does not follow level");
  level_floor_a: assert property (left_atten_level_o >= 8'h80)
    else $error("level below mute floor");
  ramp_unit_a: assert property ($changed(left_atten_level_o) |->
    (left_atten_level_o - $past(left_atten_level_o) == 8'h01) ||
    ($past(left_atten_level_o) - left_atten_level_o == 8'h01))
    else $error("level moved more than one step");
  ramp_gap_a: assert property ((RAMP_STEP_CYCLES > 1) && $changed(left_atten_level_o) |=>
    $stable(left_atten_level_o))
    else $error("ramp stepped on consecutive cycles");
  fmt_rsvd_a: assert property (input_format_rsvd_o == ($past(input_format_sel_o) >= 3'h6))
    else $error("format reserved flag wrong");
  rate_rsvd_a: assert property (deemph_rate_rsvd_o == ($past(deemph_rate_sel_o) == 2'h3))
    else $error("rate reserved flag wrong");
  // Main scenarios
  cover property (write_strobe_o);
  cover property (frame_reject_o);
  cover property ($rose(left_muted_o));
endmodule
`default_nettype wire

// [testbench/sdm_host_model.sv]
/* Host model driving the three control pins.
   Assumes the bench starts one frame at a time. */
`timescale 1ns/100ps
`default_nettype none
module sdm_host_model (
  output logic ctl_serial_in_o,
  output logic ctl_shift_clk_o,
  output logic ctl_latch_o
);
  // Idle: latch high, shift clock still, data pulled down
  initial
  begin
    ctl_serial_in_o = 1'b0;
    ctl_shift_clk_o = 1'b0;
    ctl_latch_o = 1'b1;
  end
  // One frame of n shift clocks at 160 ns, top bit first
  task send(input logic [15:0] f, input int n);
    #3 ctl_latch_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      ctl_serial_in_o = (i < 16) ? f[15 - i] : 1'b0;
      #40 ctl_shift_clk_o = 1'b1;
      #80 ctl_shift_clk_o = 1'b0;
      #40;
    end
    ctl_serial_in_o = 1'b0;
    ctl_latch_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/test_sdm_mode_regs.sv]
/* Bench for the mode-register bank, frames sent by the host model.
   Assumes the checker and host model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module test_sdm_mode_regs;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  wire sd, sc, sl, lm, rm, ov, lsm, rsm, ld, rd, de, drr, fr, rol, zm, zp, ph, ws, rj;
  wire [7:0] lc, rc, ll, rl, test_reserved_bit;
  wire [1:0] dr;
  wire [2:0] fmt;
  wire [7:0] img [0:6];
  int n_fail = 0;
  int n_checks = 0;
  int k;
  logic [7:0] held;
  logic [7:0] vals [0:6] = '{8'h81, 8'h10, 8'h43, 8'h73, 8'h25, 8'h00, 8'h07};
  // Register images rebuilt from field outputs
  assign img[0] = lc;
  assign img[1] = rc;
  assign img[2] = {1'b0, ov, 4'h0, rsm, lsm};
  assign img[3] = {1'b0, dr, de, 2'h0, rd, ld};
  assign img[4] = {2'h0, rol, 2'h0, fmt};
  assign img[5] = test_reserved_bit;
  assign img[6] = {5'h0, zm, zp, ph};
  always #5 clk_sys_i = ~clk_sys_i;
  sdm_host_model host (.ctl_serial_in_o(sd), .ctl_shift_clk_o(sc), .ctl_latch_o(sl));
  // Short ramp step keeps the run brief
  sdm_mode_regs #(.RAMP_STEP_CYCLES(4)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .ctl_serial_in_i(sd), .ctl_shift_clk_i(sc), .ctl_latch_i(sl),
    .left_atten_code_o(lc), .right_atten_code_o(rc),
    .left_atten_level_o(ll), .right_atten_level_o(rl),
    .left_muted_o(lm), .right_muted_o(rm), .oversample_128_o(ov),
    .left_soft_mute_o(lsm), .right_soft_mute_o(rsm),
    .left_output_disable_o(ld), .right_output_disable_o(rd),
    .deemph_enable_o(de), .deemph_rate_sel_o(dr), .deemph_rate_rsvd_o(drr),
    .input_format_sel_o(fmt), .input_format_rsvd_o(fr), .rolloff_sel_o(rol),
    .zero_flag_mode_sel_o(zm), .zero_flag_polarity_o(zp), .output_phase_invert_o(ph),
    .test_reserved_bit_o(test_reserved_bit), .write_strobe_o(ws), .frame_reject_o(rj)
  );
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task bound(input int lim);
    if (k >= lim)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  // One frame, then wait for the commit or reject pulse
  task wr(input logic [6:0] idx, input logic [7:0] d, input int n, input logic ok);
    host.send({1'b0, idx, d}, n);
    for (k = 0; k < 20 && (ws | rj) !== 1'b1; k++)
      @(negedge clk_sys_i);
    bound(20);
    check({7'h0, ws}, {7'h0, ok});
    check({7'h0, rj}, {7'h0, !ok});
    repeat (5) @(negedge clk_sys_i);
  endtask
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    // Reset values
    check(lc, 8'hff);
    check(ll, 8'hff);
    check(img[2], 8'h00);
    check(img[3], 8'h00);
    check(img[4], 8'h05);
    check(img[6], 8'h00);
    // Every register through its index
    for (int i = 0; i < 7; i++)
    begin
      wr(7'h10 + i[6:0], vals[i], 16, 1'b1);
      check(img[i], vals[i]);
    end
    // Bad indices and bad counts leave the bank alone
    wr(7'h17, 8'h55, 16, 1'b0);
    wr(7'h0f, 8'h55, 16, 1'b0);
    wr(7'h10, 8'h55, 15, 1'b0);
    wr(7'h10, 8'h55, 17, 1'b0);
    for (int i = 0; i < 7; i++)
      check(img[i], vals[i]);
    // Every format and rate code
    for (int i = 0; i < 8; i++)
    begin
      wr(7'h14, {5'h0, i[2:0]}, 16, 1'b1);
      check({5'h0, fmt}, {5'h0, i[2:0]});
      check({7'h0, fr}, {7'h0, i >= 6});
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h13, {1'b0, i[1:0], 5'h0}, 16, 1'b1);
      check({6'h0, dr}, {6'h0, i[1:0]});
      check({7'h0, drr}, {7'h0, i == 3});
    end
    // Soft mute takes the left level to the floor
    wr(7'h12, 8'h01, 16, 1'b1);
    for (k = 0; k < 1000 && lm !== 1'b1; k++)
      @(negedge clk_sys_i);
    bound(1000);
    check(ll, 8'h80);
    check(rl, 8'h80);
    check({7'h0, rm}, 8'h01);
    // Clearing mute and a full code ramp back up
    wr(7'h12, 8'h00, 16, 1'b1);
    wr(7'h10, 8'hff, 16, 1'b1);
    // Clock enable low freezes the ramp part way up
    clk_en_i = 1'b0;
    held = ll;
    repeat (20) @(negedge clk_sys_i);
    check(ll, held);
    clk_en_i = 1'b1;
    for (k = 0; k < 1000 && ll !== 8'hff; k++)
      @(negedge clk_sys_i);
    bound(1000);
    check({7'h0, lm}, 8'h00);
    // Reset in mid-run restores defaults
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    check(rc, 8'hff);
    check(img[4], 8'h05);
    repeat (3) @(negedge clk_sys_i);
    finish_test();
  end
endmodule
bind sdm_mode_regs sdm_regs_chk #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ctl_latch_i(ctl_latch_i),
  .left_atten_code_o(left_atten_code_o), .left_atten_level_o(left_atten_level_o),
  .left_muted_o(left_muted_o), .deemph_rate_sel_o(deemph_rate_sel_o),
  .deemph_rate_rsvd_o(deemph_rate_rsvd_o), .input_format_sel_o(input_format_sel_o),
  .input_format_rsvd_o(input_format_rsvd_o), .write_strobe_o(write_strobe_o),
  .frame_reject_o(frame_reject_o)
);
`default_nettype wire
